// File: inc/src_pkg.sv
// Constants and types shared by the system reset controller.
package src_pkg;

    // ****************************************************************
    // Command key and field widths
    // ****************************************************************
    localparam logic [7:0]  CMD_KEY          = 8'ha5;
    localparam int          PULSE_LEN_W      = 4;
    localparam int          PULSE_CNT_W      = 17;
    localparam int          STATE_CNT_W      = 2;
    localparam int          STARTUP_CNT_W    = 12;

    // ****************************************************************
    // Timing counts, in slow clock ticks
    // ****************************************************************
    localparam logic [STATE_CNT_W-1:0] SOFT_TICKS  = 2'h3;
    localparam logic [STATE_CNT_W-1:0] BOD_TICKS   = 2'h3;
    localparam logic [STATE_CNT_W-1:0] WDT_TICKS   = 2'h3;
    localparam logic [STATE_CNT_W-1:0] CPU_START   = 2'h3;
    localparam logic [STATE_CNT_W-1:0] CNT_ZERO    = 2'h0;
    localparam logic [STATE_CNT_W-1:0] CNT_ONE     = 2'h1;
    localparam logic [PULSE_CNT_W-1:0] PULSE_ONE   = 17'h00001;
    localparam logic [PULSE_CNT_W-1:0] PULSE_ZERO  = 17'h00000;
    localparam logic [STARTUP_CNT_W-1:0] STARTUP_DEFAULT = 12'h008;

    // ****************************************************************
    // Reset type codes
    // ****************************************************************
    localparam logic [2:0]  TYPE_POWER_UP    = 3'h0;
    localparam logic [2:0]  TYPE_WATCHDOG    = 3'h2;
    localparam logic [2:0]  TYPE_SOFTWARE    = 3'h3;
    localparam logic [2:0]  TYPE_USER        = 3'h4;
    localparam logic [2:0]  TYPE_BROWNOUT    = 3'h5;

    // ****************************************************************
    // Reset state manager states
    // ****************************************************************
    typedef enum logic [2:0] {
        ST_STARTUP,
        ST_RUN,
        ST_USER,
        ST_BOD,
        ST_WDT,
        ST_SOFT
    } src_state_e;

endpackage : src_pkg

// File: sim/src_pin_model.sv
// Reset pin model: pull-up plus an outside device that may hold the line low.
`timescale 1ns/1ps

module src_pin_model
(
    // Controller drive
    input  wire logic nrst_out,
    input  wire logic nrst_oe,
    // Outside device
    input  wire logic ext_hold,
    // Wire level
    output logic      nrst_in
);
    // Pull-up wins only when nobody pulls low, never a stale level
    assign nrst_in = !((nrst_oe && !nrst_out) || ext_hold);
endmodule : src_pin_model

// File: sim/src_reset_ctrl_sva.sv
// Port checker for the system reset controller.
`timescale 1ns/1ps

module src_reset_ctrl_sva
    import src_pkg::*;
(
    input wire logic       clk,
    input wire logic       srst,
    input wire logic       core_supply_ok,
    input wire logic       bod_reset,
    input wire logic       bod_rst_en,
    input wire logic       user_reset_enable,
    input wire logic       user_reset_irq_enable,
    input wire logic       brownout_irq_enable,
    input wire logic       cmd_wr,
    input wire logic [7:0] cmd_key,
    input wire logic       cmd_cpu_reset,
    input wire logic       cmd_periph_reset,
    input wire logic       user_reset_seen,
    input wire logic       brownout_seen,
    input wire logic [2:0] reset_type,
    input wire logic       cmd_in_progress,
    input wire logic       irq,
    input wire logic       nrst_oe,
    input wire logic       proc_nreset,
    input wire logic       periph_nreset
);
    // ****************************************************************
    // Assertions, one clock domain
    // ****************************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    property p_supply; !core_supply_ok |-> !proc_nreset && !periph_nreset && nrst_oe; endproperty
    a_supply: assert property (p_supply) else $error("supply low, resets free");
    property p_bod; bod_reset && bod_rst_en |-> !proc_nreset && !periph_nreset && nrst_oe;
    endproperty
    a_bod: assert property (p_bod) else $error("brownout, resets free");
    property p_start; $fell(srst) |-> !proc_nreset [*8]; endproperty
    a_start: assert property (p_start) else $error("startup too short");
    // Resets must already be low in the cycle of the write itself
    property p_imm; $rose(cmd_in_progress) |-> (!$past(cmd_cpu_reset) || !$past(proc_nreset))
        && (!$past(cmd_periph_reset) || !$past(periph_nreset)); endproperty
    a_imm: assert property (p_imm) else $error("command reset late");
    property p_busy; cmd_in_progress && periph_nreset && cmd_wr && cmd_periph_reset
        && core_supply_ok && !bod_reset |=> periph_nreset; endproperty
    a_busy: assert property (p_busy) else $error("write taken while busy");
    property p_key; cmd_wr && cmd_key != CMD_KEY && !cmd_in_progress |=> !cmd_in_progress;
    endproperty
    a_key: assert property (p_key) else $error("bad key accepted");
    property p_len; $rose(cmd_in_progress) |-> cmd_in_progress [*8] ##[1:16] !cmd_in_progress;
    endproperty
    a_len: assert property (p_len) else $error("command length wrong");
    property p_type; $changed(reset_type) |-> proc_nreset
        && (!$past(proc_nreset) || !$past(proc_nreset, 2)); endproperty
    a_type: assert property (p_type) else $error("type moved off release");
    property p_irq_bod; brownout_seen && brownout_irq_enable |-> irq; endproperty
    a_irq_bod: assert property (p_irq_bod) else $error("no brownout irq");
    property p_irq_usr; user_reset_seen && user_reset_irq_enable && !user_reset_enable |-> irq;
    endproperty
    a_irq_usr: assert property (p_irq_usr) else $error("no pin irq");
endmodule : src_reset_ctrl_sva

bind src_reset_ctrl src_reset_ctrl_sva chk (.*);

// File: sim/test_src_reset_ctrl.sv
// Self-checking bench for the system reset controller.
`timescale 1ns/1ps

module test_src_reset_ctrl
    import src_pkg::*;
    ;
    // ****************************************************************
    // Stimulus and observed signals
    // ****************************************************************
    logic clk = 1'b0, srst = 1'b1, slow_tick = 1'b0, core_supply_ok = 1'b1;
    logic bod_reset = 1'b0, bod_rst_en = 1'b0, wdt_fault = 1'b0, wdt_proc_only = 1'b0;
    logic user_reset_enable = 1'b1, user_reset_irq_enable = 1'b0, brownout_irq_enable = 1'b0;
    logic [3:0] ext_pulse_length = 4'h0;
    logic [7:0] cmd_key = 8'h00;
    logic cmd_wr = 1'b0, cmd_cpu_reset = 1'b0, cmd_periph_reset = 1'b0, cmd_pin_reset = 1'b0;
    logic status_rd = 1'b0, ext_hold = 1'b0, nrst_in, nrst_out, nrst_oe, irq;
    logic pin_level_status, user_reset_seen, brownout_seen, cmd_in_progress;
    logic proc_nreset, periph_nreset;
    logic [2:0] reset_type;
    logic [1:0] tcnt = 2'h0;
    int   fails = 0, total_checks = 0, n;

    src_reset_ctrl #(.STARTUP_TICKS(12'h002)) uut (.*);
    src_pin_model pin (.*);

    // 20 ns clock, slow tick every fourth cycle
    always #10 clk = !clk;
    always @(posedge clk)
    begin
        tcnt <= tcnt + 2'h1;
        slow_tick <= (tcnt == 2'h3);
    end

    // ****************************************************************
    // Tasks
    // ****************************************************************
    task automatic cyc(input int k); repeat (k) @(posedge clk); endtask : cyc
    task automatic chk_bit(input logic got, input logic exp);
        total_checks++;
        if (got !== exp)
        begin
            fails++;
            $display("unexpected at %0t: bit %b want %b", $time, got, exp);
        end
    endtask : chk_bit
    task automatic chk_type(input logic [2:0] got, input logic [2:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            fails++;
            $display("unexpected at %0t: type %h want %h", $time, got, exp);
        end
    endtask : chk_type
    // One-cycle strobe; bits left standing
    task automatic cmd(input logic [7:0] k, input logic c, input logic p, input logic e);
        @(posedge clk);
        cmd_wr <= 1'b1;
        cmd_key <= k;
        cmd_cpu_reset <= c;
        cmd_periph_reset <= p;
        cmd_pin_reset <= e;
        @(posedge clk);
        cmd_wr <= 1'b0;
        #1;
    endtask : cmd
    task automatic rd;
        @(posedge clk);
        status_rd <= 1'b1;
        @(posedge clk);
        status_rd <= 1'b0;
    endtask : rd
    // Bounded wait for release
    task automatic wait_run;
        for (int i = 0; i < 300 && proc_nreset !== 1'b1; i++) @(posedge clk);
        cyc(2);
        #1 chk_bit(proc_nreset, 1'b1);
    endtask : wait_run
    task automatic report_and_stop;
        $display("checks %0d fails %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : report_and_stop

    // ****************************************************************
    // Tests
    // ****************************************************************
    initial
    begin
        cyc(20);
        srst <= 1'b0;
        wait_run();
        chk_type(reset_type, TYPE_POWER_UP);
        cmd(8'h5a, 1'b1, 1'b1, 1'b1);
        cyc(2);
        #1 chk_bit(cmd_in_progress, 1'b0);
        chk_bit(proc_nreset, 1'b1);
        // Pin pulse for two lengths, user reset enabled all along
        for (int l = 0; l < 2; l++)
        begin
            cyc(1);
            ext_pulse_length <= 4'(l);
            cmd(CMD_KEY, 1'b0, 1'b0, 1'b1);
            n = 0;
            for (int i = 0; i < 200 && (n == 0 || nrst_oe); i++)
            begin
                @(posedge clk);
                #1 n += int'(nrst_oe === 1'b1);
            end
            chk_bit((n + 2) / 4 == (2 << l), 1'b1);
            cyc(12);
            #1 chk_bit(proc_nreset, 1'b1);
        end
        chk_type(reset_type, TYPE_POWER_UP);
        cmd(CMD_KEY, 1'b1, 1'b0, 1'b0);
        chk_bit(cmd_in_progress, 1'b1);
        chk_bit(proc_nreset, 1'b0);
        cmd(CMD_KEY, 1'b0, 1'b1, 1'b0);
        chk_bit(periph_nreset, 1'b1);
        for (n = 0; n < 100 && cmd_in_progress === 1'b1; n++) @(posedge clk);
        chk_bit(n >= 7 && n <= 20, 1'b1);
        cyc(2);
        #1 chk_type(reset_type, TYPE_SOFTWARE);
        // Outside device holds the pin well past a short pulse
        cyc(1);
        ext_pulse_length <= 4'h0;
        ext_hold <= 1'b1;
        cyc(40);
        #1 chk_bit(proc_nreset, 1'b0);
        chk_bit(periph_nreset, 1'b0);
        chk_bit(user_reset_seen, 1'b1);
        chk_bit(pin_level_status, 1'b0);
        cyc(1);
        ext_hold <= 1'b0;
        cyc(12);
        #1 chk_bit(proc_nreset, 1'b0);
        wait_run();
        chk_type(reset_type, TYPE_USER);
        rd();
        cyc(2);
        #1 chk_bit(user_reset_seen, 1'b0);
        // Pin raises an interrupt instead of a reset
        cyc(1);
        user_reset_enable <= 1'b0;
        user_reset_irq_enable <= 1'b1;
        ext_hold <= 1'b1;
        cyc(30);
        #1 chk_bit(proc_nreset, 1'b1);
        chk_bit(irq, 1'b1);
        cyc(1);
        ext_hold <= 1'b0;
        cyc(12);
        rd();
        cyc(2);
        #1 chk_bit(irq, 1'b0);
        // Brownout with its reset disabled, then enabled
        cyc(1);
        brownout_irq_enable <= 1'b1;
        bod_reset <= 1'b1;
        cyc(20);
        #1 chk_bit(proc_nreset, 1'b1);
        chk_bit(brownout_seen, 1'b1);
        chk_bit(irq, 1'b1);
        cyc(1);
        bod_reset <= 1'b0;
        cyc(12);
        rd();
        cyc(2);
        #1 chk_bit(brownout_seen, 1'b0);
        cyc(1);
        bod_rst_en <= 1'b1;
        bod_reset <= 1'b1;
        cyc(1);
        #1 chk_bit(nrst_oe, 1'b1);
        cyc(12);
        bod_reset <= 1'b0;
        cyc(12);
        #1 chk_bit(proc_nreset, 1'b0);
        wait_run();
        chk_type(reset_type, TYPE_BROWNOUT);
        cyc(1);
        wdt_fault <= 1'b1;
        cyc(8);
        wdt_fault <= 1'b0;
        wait_run();
        chk_type(reset_type, TYPE_WATCHDOG);
        // Supply drop acts before any clock edge
        cyc(1);
        core_supply_ok <= 1'b0;
        #1 chk_bit(periph_nreset, 1'b0);
        cyc(3);
        core_supply_ok <= 1'b1;
        wait_run();
        chk_type(reset_type, TYPE_POWER_UP);
        report_and_stop();
    end

    // Watchdog, several times the test length
    initial
    begin
        #100000;
        fails++;
        report_and_stop();
    end
endmodule : test_src_reset_ctrl

// File: src/src_reset_ctrl.sv
// System reset controller: reset sources, reset outputs, pin shaping, cause.
// Operation
// R1: Pin sampled on slow ticks; low reports a user reset request.
// R2: User reset disabled: a low pin starts no user reset.
// R3: Pin level always readable as a status bit.
// R4: Pin fall sets a sticky flag, cleared by status read.
// R5: Pin raises the interrupt instead of a reset when enabled.
// R6: Pin pulse lasts 2^(length+1) slow ticks.
// R7: Brownout, reset disabled: sticky flag only, cleared on read.
// R8: Brownout flag raises the interrupt when enabled.
// R9: Type field updates only at processor release.
// R10: Power-on holds resets for the startup count, reports power-up.
// R11: Supply low asserts all resets without a clock.
// R12: User reset asserts processor and peripheral resets.
// R13: User reset ends two resync plus three ticks after pin rise.
// R14: User reset release loads type 0x4.
// R15: Pin held low externally keeps internal resets asserted.
// R16: Brownout request asserts all resets at once.
// R17: Brownout ends three ticks after resynced request; pulses pin.
// R18: Brownout release loads type 0x5.
// R19: Three command bits act alone or together.
// R20: Software reset lasts three ticks, released on a tick.
// R21: Software resets assert as soon as the write is seen.
// R22: Own software pin pulse never enters user reset.
// R23: Software type recorded only with the processor bit.
// R24: Busy flag blocks writes until the command ends.
// R25: Command write needs key 0xA5, else ignored.
// R26: Priority: power-up, brownout, watchdog, software, user.
// R27: Type codes: power-up 000, watchdog 010, software 011.
// R28: Writes cross to the slow tick domain before sequencing.
`timescale 1ns/1ps

module src_reset_ctrl
    import src_pkg::*;
#(
    parameter logic [STARTUP_CNT_W-1:0] STARTUP_TICKS = STARTUP_DEFAULT
)
(
    // Clock, reset and slow clock tick
    input  wire logic                    clk,
    input  wire logic                    srst,
    input  wire logic                    slow_tick,
    // Supply monitors
    input  wire logic                    core_supply_ok,
    input  wire logic                    bod_reset,
    input  wire logic                    bod_rst_en,
    // Watchdog
    input  wire logic                    wdt_fault,
    input  wire logic                    wdt_proc_only,
    // Mode settings
    input  wire logic                    user_reset_enable,
    input  wire logic                    user_reset_irq_enable,
    input  wire logic                    brownout_irq_enable,
    input  wire logic [PULSE_LEN_W-1:0]  ext_pulse_length,
    // Command write
    input  wire logic                    cmd_wr,
    input  wire logic [7:0]              cmd_key,
    input  wire logic                    cmd_cpu_reset,
    input  wire logic                    cmd_periph_reset,
    input  wire logic                    cmd_pin_reset,
    // Status read
    input  wire logic                    status_rd,
    output logic                         pin_level_status,
    output logic                         user_reset_seen,
    output logic                         brownout_seen,
    output logic [2:0]                   reset_type,
    output logic                         cmd_in_progress,
    output logic                         irq,
    // Reset pin, open drain
    input  wire logic                    nrst_in,
    output logic                         nrst_out,
    output logic                         nrst_oe,
    // Reset outputs, active low
    output logic                         proc_nreset,
    output logic                         periph_nreset
);

    // ****************************************************************
    // Declarations
    // ****************************************************************
    src_state_e                 state_q;
    logic [STATE_CNT_W-1:0]     cnt_q;
    logic [STARTUP_CNT_W-1:0]   start_cnt_q;
    logic                       pin_s1_q;
    logic                       pin_s2_q;
    logic                       bod_s1_q;
    logic                       bod_s2_q;
    logic                       pin_lvl_q;
    logic                       bod_lvl_q;
    logic                       proc_q;
    logic                       periph_q;
    logic                       soft_cpu_q;
    logic                       soft_per_q;
    logic                       soft_pin_q;
    logic                       soft_pend_q;
    logic [PULSE_CNT_W-1:0]     pulse_cnt_q;
    logic                       pulse_on_q;
    logic                       self_drive_q;
    logic [2:0]                 pend_type_q;
    logic                       pend_valid_q;
    logic                       cmd_accept;
    logic                       bod_now;
    logic                       user_req;
    logic                       pulse_start;
    logic                       proc_release;
    logic [PULSE_CNT_W-1:0]     pulse_len;
    logic                       pin_fall;
    logic                       bod_rise;

    // ****************************************************************
    // Sampling and edge detection
    // ****************************************************************
    // Levels every clock for status and edges; resync only on slow ticks
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            pin_s1_q  <= 1'b1;
            pin_s2_q  <= 1'b1;
            bod_s1_q  <= 1'b0;
            bod_s2_q  <= 1'b0;
            pin_lvl_q <= 1'b1;
            bod_lvl_q <= 1'b0;
        end
        else
        begin
            pin_lvl_q <= nrst_in;
            bod_lvl_q <= bod_reset;
            if (slow_tick)
            begin
                pin_s1_q <= nrst_in;  // [R1]
                pin_s2_q <= pin_s1_q;
                bod_s1_q <= bod_reset;
                bod_s2_q <= bod_s1_q;
            end
        end
    end

    assign pin_level_status = pin_lvl_q;  // [R3]
    assign pin_fall         = pin_lvl_q & ~nrst_in;
    assign bod_rise         = ~bod_lvl_q & bod_reset;

    // ****************************************************************
    // Status flags and interrupt
    // ****************************************************************
    // Sticky flags; a new event wins over the clearing read
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            user_reset_seen <= 1'b0;
            brownout_seen   <= 1'b0;
        end
        else
        begin
            if (pin_fall)
                user_reset_seen <= 1'b1;  // [R4]
            else if (status_rd)
                user_reset_seen <= 1'b0;  // [R4]
            if (bod_rise && !bod_rst_en)
                brownout_seen <= 1'b1;  // [R7]
            else if (status_rd)
                brownout_seen <= 1'b0;  // [R7]
        end
    end

    // Interrupt from flags; pin interrupt only while user reset disabled
    assign irq = (user_reset_seen & user_reset_irq_enable & ~user_reset_enable)  // [R5]
               | (brownout_seen & brownout_irq_enable);  // [R8]

    // ****************************************************************
    // Command acceptance
    // ****************************************************************

    // Key must match and no command busy; otherwise the write is dropped
    assign cmd_accept = cmd_wr
                      & (cmd_key == CMD_KEY)  // [R25]
                      & ~cmd_in_progress  // [R24]
                      & (cmd_cpu_reset | cmd_periph_reset | cmd_pin_reset)  // [R19]
                      & (state_q == ST_RUN);  // [R26]
    // Command bits held until the command ends; pending flag until the slow side picks it up
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            soft_cpu_q      <= 1'b0;
            soft_per_q      <= 1'b0;
            soft_pin_q      <= 1'b0;
            soft_pend_q     <= 1'b0;
            cmd_in_progress <= 1'b0;
        end
        else if (cmd_accept)
        begin
            soft_cpu_q      <= cmd_cpu_reset;  // [R19]
            soft_per_q      <= cmd_periph_reset;
            soft_pin_q      <= cmd_pin_reset;
            soft_pend_q     <= 1'b1;  // [R28]
            cmd_in_progress <= 1'b1;  // [R24]
        end
        else
        begin
            if (slow_tick && soft_pend_q)
                soft_pend_q <= 1'b0;  // [R28]
            if ((state_q == ST_SOFT && slow_tick && cnt_q == CNT_ONE)
                || (state_q != ST_SOFT && state_q != ST_RUN))
            begin
                // Command done, or a higher source took over
                cmd_in_progress <= 1'b0;  // [R24]
                soft_cpu_q      <= 1'b0;
                soft_per_q      <= 1'b0;
                soft_pin_q      <= 1'b0;
                soft_pend_q     <= 1'b0;
            end
        end
    end

    // ****************************************************************
    // Reset state manager
    // ****************************************************************
    assign bod_now  = bod_rst_en & bod_reset;
    // Pin low counts only when enabled and not our own pulse
    assign user_req = ~pin_s2_q & user_reset_enable & ~self_drive_q;  // [R2] [R22]

    // Sequencer advancing on slow ticks
    always_ff @(posedge clk)
    begin
        if (srst || !core_supply_ok)
        begin
            state_q     <= ST_STARTUP;  // [R10] [R11]
            cnt_q       <= CNT_ZERO;
            start_cnt_q <= '0;
        end
        else if (bod_now && state_q != ST_STARTUP)
        begin
            state_q <= ST_BOD;  // [R16] [R26]
            cnt_q   <= BOD_TICKS;
        end
        else if (slow_tick)
        begin
            case (state_q)
                ST_STARTUP:
                begin
                    if (start_cnt_q == STARTUP_TICKS)
                        state_q <= ST_RUN;  // [R10]
                    else
                        start_cnt_q <= start_cnt_q + 1'b1;
                end
                ST_RUN:
                begin
                    if (wdt_fault)
                    begin
                        state_q <= ST_WDT;  // [R26]
                        cnt_q   <= WDT_TICKS;
                    end
                    else if (soft_pend_q)
                    begin
                        state_q <= ST_SOFT;  // [R28]
                        cnt_q   <= SOFT_TICKS;
                    end
                    else if (user_req)
                    begin
                        state_q <= ST_USER;  // [R1] [R12]
                        cnt_q   <= CPU_START;
                    end
                end
                ST_USER, ST_BOD, ST_WDT:
                begin
                    // User and brownout hold while the resynced source stands; all three then count down
                    if (state_q == ST_USER && !pin_s2_q)
                        cnt_q <= CPU_START;  // [R15]
                    else if (state_q == ST_BOD && bod_s2_q)
                        cnt_q <= BOD_TICKS;
                    else if (cnt_q == CNT_ONE)
                        state_q <= ST_RUN;  // [R13] [R17]
                    else
                        cnt_q <= cnt_q - 1'b1;  // [R13] [R17]
                end
                ST_SOFT:
                begin
                    if (wdt_fault)
                    begin
                        state_q <= ST_WDT;  // [R26]
                        cnt_q   <= WDT_TICKS;
                    end
                    else if (cnt_q == CNT_ONE)
                        state_q <= ST_RUN;  // [R20]
                    else
                        cnt_q <= cnt_q - 1'b1;  // [R20]
                end
                default:
                begin
                    state_q <= ST_STARTUP;
                    cnt_q   <= CNT_ZERO;
                end
            endcase
        end
    end

    // Registered reset levels per state
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            proc_q   <= 1'b1;
            periph_q <= 1'b1;
        end
        else
        begin
            // Software levels follow the command bits; run releases both
            proc_q   <= (state_q == ST_SOFT) ? soft_cpu_q : (state_q != ST_RUN);  // [R12]
            periph_q <= (state_q == ST_SOFT) ? soft_per_q
                      : (state_q == ST_WDT) ? ~wdt_proc_only
                      : (state_q != ST_RUN);
        end
    end

    // Immediate assertion paths bypass the flops; release stays on ticks
    assign proc_nreset   = core_supply_ok & ~bod_now & ~proc_q  // [R11] [R16]
                         & ~(cmd_accept & cmd_cpu_reset)  // [R21]
                         & ~soft_cpu_q;  // [R20]
    assign periph_nreset = core_supply_ok & ~bod_now & ~periph_q  // [R11] [R16]
                         & ~(cmd_accept & cmd_periph_reset)  // [R21]
                         & ~soft_per_q;

    // ****************************************************************
    // Pin pulse shaping
    // ****************************************************************
    // Widened first so the longest setting does not wrap to zero
    assign pulse_len   = PULSE_ONE << ({1'b0, ext_pulse_length} + 5'h01);  // [R6]
    assign pulse_start = slow_tick & (
                         (state_q == ST_RUN & soft_pend_q & soft_pin_q & ~wdt_fault)  // [R19]
                       | (state_q == ST_RUN & wdt_fault & ~wdt_proc_only)
                       | (state_q == ST_RUN & user_req & ~wdt_fault & ~soft_pend_q)
                       | (state_q == ST_BOD & ~pulse_on_q & cnt_q == BOD_TICKS
                          & ~bod_s2_q));  // [R17]

    // Pulse counter counts slow ticks while the pin is driven
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            pulse_on_q  <= 1'b0;
            pulse_cnt_q <= PULSE_ZERO;
        end
        else if (pulse_start && !pulse_on_q)
        begin
            pulse_on_q  <= 1'b1;  // [R6]
            pulse_cnt_q <= pulse_len;
        end
        else if (pulse_on_q && slow_tick)
        begin
            if (pulse_cnt_q == PULSE_ONE)
                pulse_on_q <= 1'b0;  // [R6]
            pulse_cnt_q <= pulse_cnt_q - PULSE_ONE;
        end
    end

    // Own drive blanks user entry until the pin is seen high again
    always_ff @(posedge clk)
    begin
        if (srst)
            self_drive_q <= 1'b0;
        else if (pulse_start)
            self_drive_q <= 1'b1;  // [R22]
        else if (!pulse_on_q && pin_s2_q && slow_tick)
            self_drive_q <= 1'b0;
    end

    // Open drain: drive low only while the pulse runs, supply is low or a brownout reset is requested
    assign nrst_out = 1'b0;
    assign nrst_oe  = pulse_on_q | ~core_supply_ok | bod_now;  // [R11] [R16]

    // ****************************************************************
    // Reset type capture
    // ****************************************************************
    // Cause is held pending and loaded only at processor release
    always_ff @(posedge clk)
    begin
        if (srst || !core_supply_ok)
        begin
            pend_type_q  <= TYPE_POWER_UP;  // [R27]
            pend_valid_q <= 1'b1;  // [R10]
        end
        else
        begin
            case (state_q)
                ST_USER: pend_type_q <= TYPE_USER;  // [R14]
                ST_BOD:  pend_type_q <= TYPE_BROWNOUT;  // [R18]
                ST_WDT:  pend_type_q <= TYPE_WATCHDOG;  // [R27]
                ST_SOFT: pend_type_q <= TYPE_SOFTWARE;  // [R27]
                default: pend_type_q <= pend_type_q;
            endcase
            if (state_q == ST_SOFT)
                pend_valid_q <= soft_cpu_q;  // [R23]
            else if (state_q != ST_RUN && state_q != ST_STARTUP)
                pend_valid_q <= 1'b1;
            else if (proc_release)
                pend_valid_q <= 1'b0;
        end
    end

    assign proc_release = proc_q & (state_q == ST_RUN);

    // Visible field changes at the release moment only
    always_ff @(posedge clk)
    begin
        if (srst)
            reset_type <= TYPE_POWER_UP;
        else if (proc_release && pend_valid_q)
            reset_type <= pend_type_q;  // [R9]
    end

endmodule : src_reset_ctrl
